// [hw/dow_nibble_write.sv]
// write-nvm command executor with mirror, otp image and wishbone registers
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Function
// [R1] command code 1001 selects the nibble write
// [R2] ignore unless address matches own address
// [R3] low nibble is data, high nibble pointer
// [R4] enabled response: addr, pointer, 11, bank, readback
// [R5] disabled response: addr, 0000, 1111, addr
// [R6] bank comes from latched initialization value
// [R7] program otp only while write enable set
// [R8] disabled: mirror still updated, address returned
// [R9] a changed address is reported as new
// [R10] master waits out programming before next command
// [R11] readback recommended; no internal program check
// [R12] every write updates mirror and check; lock flags
// [R13] unused pointers: no write, address returned
// [R14] bank0 nibble7: bit3 to user lock
// [R15] bank0 nibble8: bits3..2 to filter select
// [R16] bank0 nibble10: bit3 to id select
// [R17] bank1 nibble6: bits1..0 to sense setting
// [R18] bank1 nibble7: four bits to device address
// [R19] bank1 nibbles8,9: user words 1 and 2
// [R20] long formats only; global address ignored
// [R21] check command crc, append response crc
module dow_nibble_write #(
  parameter int PROG_BIT_CYCLES = dow_pkg::PROG_BIT_CYCLES,
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire dow_pkg::dow_cmd_t cmd,
  output dow_pkg::dow_rsp_t rsp,
  output logic busy,
  output logic check_error,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  output logic [31:0] wb_dat_r,
  output logic wb_ack
);

  if (PROG_BIT_CYCLES < 1 || longint'(PROG_BIT_CYCLES) * dow_pkg::MAX_PROG_BITS >= 2**TW)
  begin : g_chk
    $error("dow_nibble_write: PROG_BIT_CYCLES does not fit the timer");
  end

  //////////////////////////////////////////////////////////////////////////////
  // field helpers

  // which data bits a pointer stores; zero marks an unused pointer
  function automatic logic [3:0] nib_mask(input logic [1:0] bank, input logic [3:0] ptr);
    nib_mask = 4'h0; // [R13]
    if (bank == dow_pkg::BANK0)
    begin
      case (ptr)
        dow_pkg::NIB_B0_LOCK: nib_mask = 4'h8; // [R14]
        dow_pkg::NIB_B0_FILT: nib_mask = 4'hc; // [R15]
        dow_pkg::NIB_B0_IDSEL: nib_mask = 4'h8; // [R16]
        default: nib_mask = 4'h0;
      endcase
    end
    else if (bank == dow_pkg::BANK1)
    begin
      case (ptr)
        dow_pkg::NIB_B1_SENSE: nib_mask = 4'h3; // [R17]
        dow_pkg::NIB_B1_ADDR: nib_mask = 4'hf; // [R18]
        dow_pkg::NIB_B1_UW1: nib_mask = 4'hf; // [R19]
        dow_pkg::NIB_B1_UW2: nib_mask = 4'hf; // [R19]
        default: nib_mask = 4'h0;
      endcase
    end
  endfunction : nib_mask

  // store the masked nibble into its field; unused pointers leave cfg alone
  function automatic dow_pkg::dow_cfg_t nib_apply(input dow_pkg::dow_cfg_t c,
      input logic [1:0] bank, input logic [3:0] ptr, input logic [3:0] d);
    nib_apply = c;
    if (bank == dow_pkg::BANK0)
    begin
      case (ptr)
        dow_pkg::NIB_B0_LOCK: nib_apply.lock_user = d[3]; // [R14]
        dow_pkg::NIB_B0_FILT: nib_apply.filter_select = d[3:2]; // [R15]
        dow_pkg::NIB_B0_IDSEL: nib_apply.id_select_bit = d[3]; // [R16]
        default: nib_apply = c;
      endcase
    end
    else if (bank == dow_pkg::BANK1)
    begin
      case (ptr)
        dow_pkg::NIB_B1_SENSE: nib_apply.sense_setting = d[1:0]; // [R17]
        dow_pkg::NIB_B1_ADDR: nib_apply.dev_addr = d; // [R18]
        dow_pkg::NIB_B1_UW1: nib_apply.user_word_1 = d; // [R19]
        dow_pkg::NIB_B1_UW2: nib_apply.user_word_2 = d; // [R19]
        default: nib_apply = c;
      endcase
    end
  endfunction : nib_apply

  // register contents at a pointer, fields in their nibble positions
  function automatic logic [3:0] nib_read(input dow_pkg::dow_cfg_t c,
      input logic [1:0] bank, input logic [3:0] ptr);
    nib_read = c.dev_addr; // [R13]
    if (bank == dow_pkg::BANK0)
    begin
      case (ptr)
        dow_pkg::NIB_B0_LOCK: nib_read = {c.lock_user, 3'h0};
        dow_pkg::NIB_B0_FILT: nib_read = {c.filter_select, 2'h0};
        dow_pkg::NIB_B0_IDSEL: nib_read = {c.id_select_bit, 3'h0};
        default: nib_read = c.dev_addr;
      endcase
    end
    else if (bank == dow_pkg::BANK1)
    begin
      case (ptr)
        dow_pkg::NIB_B1_SENSE: nib_read = {2'h0, c.sense_setting};
        dow_pkg::NIB_B1_ADDR: nib_read = c.dev_addr;
        dow_pkg::NIB_B1_UW1: nib_read = c.user_word_1;
        dow_pkg::NIB_B1_UW2: nib_read = c.user_word_2;
        default: nib_read = c.dev_addr;
      endcase
    end
  endfunction : nib_read

  // error-detection value over the user-programmable contents
  function automatic logic [7:0] cfg_fold(input dow_pkg::dow_cfg_t c);
    logic [31:0] w;
    w = 32'(c);
    cfg_fold = w[7:0] ^ w[15:8] ^ w[23:16] ^ w[31:24];
  endfunction : cfg_fold

  //////////////////////////////////////////////////////////////////////////////
  // state

  dow_pkg::dow_state_t state_q, state_d;
  dow_pkg::dow_cfg_t mirror_q;
  dow_pkg::dow_cfg_t otp_q;
  dow_pkg::dow_cfg_t pend_q;
  logic [7:0] check_q;
  logic otp_we_q;
  logic [1:0] bank_q;
  logic [15:0] rsp_word_q;
  logic [7:0] rsp_crc_q;
  logic rsp_flag_q;
  logic ack_q;

  //////////////////////////////////////////////////////////////////////////////
  // command decode

  wire logic [15:0] cmd_word = {cmd.data, cmd.addr, cmd.code};
  wire logic [7:0] cmd_crc;
  wire logic [3:0] wr_data = cmd.data[3:0]; // [R3]
  wire logic [3:0] wr_ptr = cmd.data[7:4]; // [R3]
  wire logic crc_ok = (cmd_crc == cmd.crc); // [R21]
  wire logic code_ok = (cmd.code == dow_pkg::CMD_WRITE_NVM); // [R1]
  wire logic addr_ok = (cmd.addr == mirror_q.dev_addr) && // [R2]
    (cmd.addr != dow_pkg::GLOBAL_ADDR); // [R20]
  // commands arriving mid-programming are dropped; the master must wait
  wire logic accept = (state_q == dow_pkg::ST_IDLE) && cmd.valid && cmd.long_fmt && // [R20]
    code_ok && addr_ok && crc_ok; // [R10]
  wire logic [3:0] wr_mask = nib_mask(bank_q, wr_ptr); // [R6]
  wire logic used = (wr_mask != 4'h0);
  wire dow_pkg::dow_cfg_t new_cfg = nib_apply(mirror_q, bank_q, wr_ptr, wr_data); // [R12]
  // otp cells only go from blank to programmed, so programming ors in
  wire dow_pkg::dow_cfg_t new_otp = otp_q | nib_apply(otp_q, bank_q, wr_ptr, wr_data);
  wire logic do_prog = accept && otp_we_q && used; // [R7]
  wire logic [3:0] new_addr = new_cfg.dev_addr; // [R9]
  wire logic [3:0] rd_back = nib_read(new_cfg, bank_q, wr_ptr); // [R13]
  wire logic [15:0] rsp_enabled = {new_addr, wr_ptr, dow_pkg::RSP_ONES2, bank_q, rd_back}; // [R4]
  wire logic [15:0] rsp_disabled = {new_addr, dow_pkg::RSP_ZERO4, dow_pkg::RSP_ONES4,
    new_addr}; // [R5] [R8]
  wire logic [15:0] rsp_word_d = otp_we_q ? rsp_enabled : rsp_disabled;
  wire logic [7:0] rsp_crc_d;

  // programming time scales with the number of set bits, never below one
  logic [2:0] ones;
  always_comb
  begin
    ones = 3'h0;
    for (int i = 0; i < 4; i++)
      ones = ones + 3'(wr_data[i] & wr_mask[i]);
    if (ones == 3'h0)
      ones = 3'h1;
  end
  wire logic [TW-1:0] prog_load = TW'(PROG_BIT_CYCLES) * TW'(ones);
  wire logic prog_done;

  dow_crc8 #(
    .WIDTH(16)
  ) u_cmd_crc (
    .data(cmd_word),
    .crc(cmd_crc)
  );

  dow_crc8 #(
    .WIDTH(16)
  ) u_rsp_crc (
    .data(rsp_word_d),
    .crc(rsp_crc_d)
  );

  dow_prog_timer #(
    .TW(TW)
  ) u_timer (
    .clk(clk),
    .rst(rst),
    .start(do_prog),
    .load(prog_load),
    .done(prog_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // sequencing

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      dow_pkg::ST_IDLE:
        if (do_prog)
          state_d = dow_pkg::ST_PROG;
        else if (accept)
          state_d = dow_pkg::ST_RESP;
      dow_pkg::ST_PROG:
        if (prog_done)
          state_d = dow_pkg::ST_RESP;
      dow_pkg::ST_RESP:
        state_d = dow_pkg::ST_IDLE;
      default:
        state_d = dow_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      state_q <= dow_pkg::ST_IDLE;
    else
      state_q <= state_d;
  end

  // mirror and check value move together on every accepted write
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mirror_q <= dow_pkg::CFG_RST;
      check_q <= cfg_fold(dow_pkg::CFG_RST);
      rsp_word_q <= '0;
      rsp_crc_q <= '0;
    end
    else if (accept)
    begin
      mirror_q <= new_cfg; // [R8] [R12]
      check_q <= cfg_fold(new_cfg); // [R12]
      rsp_word_q <= rsp_word_d;
      rsp_crc_q <= rsp_crc_d; // [R21]
    end
  end

  // the otp image takes the new bits when the programming time has run out
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      otp_q <= dow_pkg::OTP_BLANK;
      pend_q <= dow_pkg::OTP_BLANK;
    end
    else
    begin
      if (do_prog)
        pend_q <= new_otp; // [R7]
      if (prog_done)
        otp_q <= pend_q; // [R7]
    end
  end

  assign busy = (state_q != dow_pkg::ST_IDLE);
  // no verify of programmed cells: only a locked part compares image and check
  assign check_error = mirror_q.lock_user && (cfg_fold(otp_q) != check_q); // [R12] [R11]
  assign rsp.valid = (state_q == dow_pkg::ST_RESP);
  assign rsp.word = rsp_word_q;
  assign rsp.crc = rsp_crc_q;

  //////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, every address answered

  wire logic wb_req = wb_cyc && wb_stb && !ack_q;
  wire logic wb_wr = wb_req && wb_we;
  wire logic sel_ctrl = (wb_adr == dow_pkg::REG_CTRL);
  wire logic sel_status = (wb_adr == dow_pkg::REG_STATUS);
  wire logic sel_config = (wb_adr == dow_pkg::REG_CONFIG);
  wire logic sel_otp = (wb_adr == dow_pkg::REG_OTP);
  wire logic sel_resp = (wb_adr == dow_pkg::REG_RESP);
  wire logic ctrl_wr = wb_wr && sel_ctrl && wb_sel[0];
  wire logic resp_clr = wb_wr && sel_status && wb_sel[0] && wb_dat_w[dow_pkg::ST_RESP_BIT];
  wire logic [31:0] ctrl_rd = (32'(otp_we_q) << dow_pkg::CTRL_WE_BIT) |
    (32'(bank_q) << dow_pkg::CTRL_BANK_LSB);
  wire logic [31:0] status_rd = (32'(busy) << dow_pkg::ST_BUSY_BIT) |
    (32'(check_error) << dow_pkg::ST_MISMATCH_BIT) |
    (32'(rsp_flag_q) << dow_pkg::ST_RESP_BIT);
  wire logic [31:0] rd_mux = sel_ctrl ? ctrl_rd :
    sel_status ? status_rd :
    sel_config ? 32'(mirror_q) :
    sel_otp ? 32'(otp_q) :
    sel_resp ? {8'h00, rsp_word_q, rsp_crc_q} : 32'h0000_0000;

  // enable and bank stand in for the values latched by initialization
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      otp_we_q <= 1'b0;
      bank_q <= dow_pkg::BANK0;
    end
    else if (ctrl_wr)
    begin
      otp_we_q <= wb_dat_w[dow_pkg::CTRL_WE_BIT]; // [R7]
      bank_q <= wb_dat_w[dow_pkg::CTRL_BANK_LSB +: 2]; // [R6]
    end
  end

  // a response leaving in the clearing cycle keeps the flag set
  always_ff @(posedge clk)
  begin
    if (rst)
      rsp_flag_q <= 1'b0;
    else if (rsp.valid)
      rsp_flag_q <= 1'b1;
    else if (resp_clr)
      rsp_flag_q <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ack_q <= 1'b0;
      wb_dat_r <= '0;
    end
    else
    begin
      ack_q <= wb_req;
      if (wb_req)
        wb_dat_r <= rd_mux;
    end
  end

  assign wb_ack = ack_q;

endmodule : dow_nibble_write

// [shared/dow_pkg.sv]
// constants, layouts and types for the otp nibble write block
package dow_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // command decoding
  localparam logic [3:0] CMD_WRITE_NVM = 4'h9;
  localparam logic [3:0] GLOBAL_ADDR = 4'h0;
  localparam logic [1:0] BANK0 = 2'h0;
  localparam logic [1:0] BANK1 = 2'h1;
  localparam logic [3:0] NIB_B0_LOCK = 4'h7;
  localparam logic [3:0] NIB_B0_FILT = 4'h8;
  localparam logic [3:0] NIB_B0_IDSEL = 4'ha;
  localparam logic [3:0] NIB_B1_SENSE = 4'h6;
  localparam logic [3:0] NIB_B1_ADDR = 4'h7;
  localparam logic [3:0] NIB_B1_UW1 = 4'h8;
  localparam logic [3:0] NIB_B1_UW2 = 4'h9;
  localparam logic [1:0] RSP_ONES2 = 2'h3;
  localparam logic [3:0] RSP_ONES4 = 4'hf;
  localparam logic [3:0] RSP_ZERO4 = 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // timing: per-bit programming time, rounded up to whole clock cycles
  localparam longint CLK_FREQ_HZ = 64'd40000000;
  localparam longint PROG_BIT_TIME_US = 64'd100;
  localparam longint US_PER_S = 64'd1000000;
  localparam int PROG_BIT_CYCLES =
    int'((PROG_BIT_TIME_US * CLK_FREQ_HZ + US_PER_S - 64'd1) / US_PER_S);
  localparam int MAX_PROG_BITS = 4;

  ////////////////////////////////////////////////////////////////////////////
  // crc
  localparam logic [7:0] CRC_POLY = 8'h1d;
  localparam logic [7:0] CRC_INIT = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses) and fields
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CONFIG = 8'h08;
  localparam logic [7:0] REG_OTP = 8'h0c;
  localparam logic [7:0] REG_RESP = 8'h10;
  localparam int CTRL_WE_BIT = 0;
  localparam int CTRL_BANK_LSB = 4;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_MISMATCH_BIT = 1;
  localparam int ST_RESP_BIT = 2;
  localparam logic [3:0] DEV_ADDR_RST = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [3:0] dev_addr;
    logic lock_user;
    logic [1:0] filter_select;
    logic id_select_bit;
    logic [1:0] sense_setting;
    logic [3:0] user_word_1;
    logic [3:0] user_word_2;
  } dow_cfg_t;

  localparam dow_cfg_t CFG_RST = '{dev_addr: DEV_ADDR_RST, default: '0};
  localparam dow_cfg_t OTP_BLANK = '0;

  typedef struct packed {
    logic valid;
    logic long_fmt;
    logic [7:0] data;
    logic [3:0] addr;
    logic [3:0] code;
    logic [7:0] crc;
  } dow_cmd_t;

  typedef struct packed {
    logic valid;
    logic [15:0] word;
    logic [7:0] crc;
  } dow_rsp_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_RESP = 2'b10
  } dow_state_t;

endpackage : dow_pkg

// [hw/dow_crc8.sv]
// combinational crc-8 over a word, msb first
`timescale 1ns/100ps
module dow_crc8 #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] data,
  output logic [7:0] crc
);

  if (WIDTH < 1) begin : g_chk
    $error("dow_crc8: WIDTH must be at least 1");
  end

  always_comb
  begin
    crc = dow_pkg::CRC_INIT;
    for (int i = WIDTH - 1; i >= 0; i--)
    begin
      if (crc[7] ^ data[i])
        crc = {crc[6:0], 1'b0} ^ dow_pkg::CRC_POLY;
      else
        crc = {crc[6:0], 1'b0};
    end
  end

endmodule : dow_crc8

// [hw/dow_prog_timer.sv]
// down counter that times one otp programming pulse train
`timescale 1ns/100ps
module dow_prog_timer #(
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [TW-1:0] load,
  output logic done
);

  logic [TW-1:0] cnt_q;
  logic run_q;
  logic last;

  if (TW < 2) begin : g_chk
    $error("dow_prog_timer: TW must be at least 2");
  end

  assign last = run_q && (cnt_q == TW'(1));
  assign done = last;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_q <= '0;
      run_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q <= load;
      run_q <= 1'b1;
    end
    else if (run_q)
    begin
      cnt_q <= cnt_q - TW'(1);
      run_q <= !last;
    end
  end

endmodule : dow_prog_timer

// [sim/dow_nibble_write_props.sv]
// concurrent checks on the ports of the otp nibble write block
`timescale 1ns/100ps
module dow_nibble_write_props #(
  parameter int PROG_BIT_CYCLES = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire dow_pkg::dow_cmd_t cmd,
  input wire dow_pkg::dow_rsp_t rsp,
  input wire logic busy,
  input wire logic check_error,
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_w,
  input wire logic [31:0] wb_dat_r,
  input wire logic wb_ack
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [15:0] busy_cnt_q;
  logic [15:0] busy_cnt_d;
  // a counter instead of a long repetition keeps the tools fast
  assign busy_cnt_d = busy ? busy_cnt_q + 16'h1 : 16'h0;
  always_ff @(posedge clk)
  begin
    if (rst)
      busy_cnt_q <= 16'h0;
    else
      busy_cnt_q <= busy_cnt_d;
  end
  ////////////////////////////////////////////////////////////////////////////
  sequence s_wb_take;
    wb_cyc && wb_stb && !wb_ack;
  endsequence
  sequence s_cmd_seen;
    cmd.valid && !busy;
  endsequence
  sequence s_nothing;
    !busy && !rsp.valid;
  endsequence
  property p_wb_ack;
    s_wb_take |=> wb_ack;
  endproperty
  property p_ack_pulse;
    wb_ack |=> !wb_ack;
  endproperty
  property p_rsp_pulse;
    rsp.valid |-> busy ##1 !busy && !rsp.valid;
  endproperty
  property p_bad_code;
    s_cmd_seen and (cmd.code != dow_pkg::CMD_WRITE_NVM) |=> s_nothing;
  endproperty
  property p_short_fmt;
    s_cmd_seen and !cmd.long_fmt |=> s_nothing;
  endproperty
  property p_global;
    s_cmd_seen and (cmd.addr == dow_pkg::GLOBAL_ADDR) |=> s_nothing;
  endproperty
  property p_ones;
    rsp.valid |-> rsp.word[7:6] == dow_pkg::RSP_ONES2;
  endproperty
  property p_unused_low;
    rsp.valid && rsp.word[11:8] == 4'h0 |-> rsp.word[3:0] == rsp.word[15:12];
  endproperty
  property p_busy_bound;
    busy_cnt_q <= PROG_BIT_CYCLES * dow_pkg::MAX_PROG_BITS + 1;
  endproperty
  property p_busy_rise;
    $rose(busy) |-> $past(cmd.valid);
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus request not acked in the next cycle");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack longer than one cycle");
  a_rsp_pulse: assert property (p_rsp_pulse)
    else $error("response valid not a single cycle ending busy");
  a_bad_code: assert property (p_bad_code)
    else $error("command with other code was executed");
  a_short_fmt: assert property (p_short_fmt)
    else $error("short format command was executed");
  a_global: assert property (p_global)
    else $error("global address command was executed");
  a_ones: assert property (p_ones)
    else $error("response bits 7..6 not ones");
  a_unused_low: assert property (p_unused_low)
    else $error("unused pointer did not return the address");
  a_busy_bound: assert property (p_busy_bound)
    else $error("write lasted longer than four bit times");
  a_busy_rise: assert property (p_busy_rise)
    else $error("busy rose without a command");
endmodule : dow_nibble_write_props

bind dow_nibble_write dow_nibble_write_props #(.PROG_BIT_CYCLES(PROG_BIT_CYCLES)) u_props (
  .clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp), .busy(busy), .check_error(check_error),
  .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel),
  .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack));

// [sim/dow_master_model.sv]
// bus master stand-in that sends write commands and times the answer
`timescale 1ns/100ps
module dow_master_model (
  input wire logic clk,
  input wire dow_pkg::dow_rsp_t rsp,
  output dow_pkg::dow_cmd_t cmd
);
  initial cmd = '0;
  function automatic logic [7:0] crc8(input logic [15:0] d);
    logic [7:0] c;
    c = dow_pkg::CRC_INIT;
    for (int i = 15; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? dow_pkg::CRC_POLY : 8'h00);
    return c;
  endfunction : crc8
  ////////////////////////////////////////////////////////////////////////////
  // lat is 0 when no answer came; the next command waits for the answer
  task automatic issue(input logic [3:0] adr, input logic [3:0] cd, input logic [7:0] dat,
    input logic lf, input logic bad, output int lat, output logic [15:0] word,
    output logic [7:0] crc);
    int n;
    lat = 0;
    n = 0;
    @(posedge clk);
    cmd <= '{valid: 1'b1, long_fmt: lf, data: dat, addr: adr, code: cd,
      crc: crc8({dat, adr, cd}) ^ {7'h00, bad}};
    @(posedge clk);
    // released fields flip so a stale value is never mistaken for a held one
    cmd <= {1'b0, ~cmd[24:0]};
    while (lat == 0 && n < 40)
    begin
      @(posedge clk);
      n++;
      if (rsp.valid === 1'b1)
        lat = n;
    end
    word = rsp.word;
    crc = rsp.crc;
  endtask : issue
endmodule : dow_master_model

// [sim/tb.sv]
// self-checking bench for the otp nibble write block
`timescale 1ns/100ps
module tb;
  localparam int PBC = 3;
  // entries: address, code, long format, crc corrupted
  localparam logic [9:0] IGN [5] = '{10'h0a6, 10'h026, 10'h064, 10'h062, 10'h067};
  // entries: bank, pointer, data, bits programmed, readback
  localparam logic [16:0] PRG [7] = '{17'h01f81, 17'h047ac, 17'h05798, 17'h0b7a3,
    17'h0c2a5, 17'h0cd2a, 17'h0bb26};
  logic clk;
  logic rst;
  dow_pkg::dow_cmd_t cmd;
  dow_pkg::dow_rsp_t rsp;
  logic busy;
  logic check_error;
  logic wb_cyc;
  logic wb_stb;
  logic wb_we;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_w;
  logic [31:0] wb_dat_r;
  logic wb_ack;
  int n_errors;
  int checked;
  dow_nibble_write #(.PROG_BIT_CYCLES(PBC)) DUT (.clk(clk), .rst(rst), .cmd(cmd), .rsp(rsp),
    .busy(busy), .check_error(check_error), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack));
  dow_master_model mst (.clk(clk), .rsp(rsp), .cmd(cmd));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task give_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_dat_w <= dat;
    @(posedge clk);
    while (wb_ack !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    check("bus answer", 32'(k < 20), 32'h1);
  endtask : wb
  task reg_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 32'h0, rd);
    check($sformatf("register %h", adr), rd, exp);
  endtask : reg_chk
  task cmd_chk(input logic [3:0] adr, input logic [7:0] dat, input int exp_lat,
    input logic [15:0] exp_w);
    int lat;
    logic [15:0] w;
    logic [7:0] c;
    mst.issue(adr, dow_pkg::CMD_WRITE_NVM, dat, 1'b1, 1'b0, lat, w, c);
    check("latency", 32'(lat), 32'(exp_lat));
    check("response word", {16'h0, w}, {16'h0, exp_w});
    check("response crc", {24'h0, c}, {24'h0, mst.crc8(exp_w)});
  endtask : cmd_chk
  ////////////////////////////////////////////////////////////////////////////
  task t_reset;
    check("busy", {31'h0, busy}, 32'h0);
    reg_chk(dow_pkg::REG_CONFIG, 32'h4000);
    reg_chk(dow_pkg::REG_OTP, 32'h0);
    reg_chk(dow_pkg::REG_CTRL, 32'h0);
    reg_chk(8'h14, 32'h0);
  endtask : t_reset
  task t_ignored;
    int lat;
    logic [15:0] w;
    logic [7:0] c;
    for (int i = 0; i < 5; i++)
    begin
      mst.issue(IGN[i][9:6], IGN[i][5:2], 8'h87, IGN[i][1], IGN[i][0], lat, w, c);
      check("ignored command", 32'(lat), 32'h0);
    end
    reg_chk(dow_pkg::REG_CONFIG, 32'h4000);
  endtask : t_ignored
  task t_disabled;
    logic [31:0] rd;
    wb(1'b1, dow_pkg::REG_CTRL, 32'h0, rd);
    // latency counts edges after the taking edge: response valid in the first cycle
    cmd_chk(4'h1, 8'h78, 1, 16'h10f1);
    reg_chk(dow_pkg::REG_CONFIG, 32'h6000);
    reg_chk(dow_pkg::REG_OTP, 32'h0);
    check("check error", {31'h0, check_error}, 32'h1);
    reg_chk(dow_pkg::REG_STATUS, 32'h6);
    cmd_chk(4'h1, 8'h70, 1, 16'h10f1);
    check("check error", {31'h0, check_error}, 32'h0);
  endtask : t_disabled
  task t_program;
    logic [31:0] rd;
    logic [16:0] e;
    logic [3:0] cur;
    logic [3:0] na;
    cur = 4'h1;
    for (int i = 0; i < 7; i++)
    begin
      e = PRG[i];
      wb(1'b1, dow_pkg::REG_CTRL, {26'h0, e[16:15], 4'h1}, rd);
      na = (e[16:15] == dow_pkg::BANK1 && e[14:11] == dow_pkg::NIB_B1_ADDR) ? e[10:7] : cur;
      // programming ends one bit time per programmed bit after the taking edge
      cmd_chk(cur, e[14:7], (e[6:4] == 3'h0) ? 1 : PBC * e[6:4] + 1,
        {na, e[14:11], 2'b11, e[16:15], e[3:0]});
      cur = na;
    end
    reg_chk(dow_pkg::REG_CONFIG, 32'h19f5a);
    reg_chk(dow_pkg::REG_OTP, 32'h19f5a);
    wb(1'b1, dow_pkg::REG_CTRL, 32'h0, rd);
    cmd_chk(4'h6, 8'h35, 1, 16'h60f6);
    wb(1'b1, dow_pkg::REG_STATUS, 32'h4, rd);
    reg_chk(dow_pkg::REG_STATUS, 32'h0);
  endtask : t_program
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_errors = 0;
    checked = 0;
    rst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_sel = 4'hf;
    wb_dat_w = 32'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ignored();
    t_disabled();
    t_program();
    give_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule : tb
